/* rtl/lbd_pkg.sv */
// lbd_pkg: constants for the local bus address decoder and bus timer
// assumes a 100 MHz local bus clock
`default_nettype none
package lbd_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TO_8US_NS     = 8000;
    localparam int unsigned TO_64US_NS    = 64000;
    localparam int unsigned TO_256US_NS   = 256000;
    localparam int unsigned TO_8US_CYC    = (TO_8US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TO_64US_CYC   = (TO_64US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TO_256US_CYC  = (TO_256US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W         = 16;
    // timeout select codes
    localparam logic [1:0]  TSEL_8US      = 2'h0;
    localparam logic [1:0]  TSEL_64US     = 2'h1;
    localparam logic [1:0]  TSEL_256US    = 2'h2;
    localparam logic [1:0]  TSEL_INF      = 2'h3;
    // access size codes
    localparam logic [1:0]  SZ_BYTE       = 2'h0;
    localparam logic [1:0]  SZ_HALF       = 2'h1;
    localparam logic [1:0]  SZ_WORD       = 2'h2;
    // port width codes
    localparam logic [1:0]  PORT_D32      = 2'h0;
    localparam logic [1:0]  PORT_D16      = 2'h1;
    localparam logic [1:0]  PORT_D8       = 2'h2;
    localparam logic [1:0]  PORT_ANY      = 2'h3;
    localparam logic [2:0]  TT_NORMAL_MAX = 3'h1;
    localparam logic        BOOT_ROM_RST  = 1'b1;
    localparam int unsigned BOOT_ROM_BIT  = 20;
    // region bounds
    localparam logic [31:0] ROM_LOW_END   = 32'h003fffff;
    localparam logic [31:0] VME_END       = 32'hff7fffff;
    localparam logic [31:0] ROM_BASE      = 32'hff800000;
    localparam logic [31:0] RSV2M_BASE    = 32'hffc00000;
    localparam logic [31:0] SRAM_BASE     = 32'hffe00000;
    localparam logic [31:0] IO_BASE       = 32'hfff00000;
    localparam logic [31:0] IO_END        = 32'hfffeffff;
    localparam logic [31:0] A16_BASE      = 32'hffff0000;
    localparam logic [31:0] LOCAL_CONTROL_STATUS_SPACE_BASE     = 32'hfff40000;
    localparam logic [31:0] GLOBAL_CONTROL_STATUS_SPACE_BASE     = 32'hfff40100;
    localparam logic [31:0] IOCTL_BASE    = 32'hfff42000;
    localparam logic [31:0] MEMCTL_BASE   = 32'hfff43000;
    localparam logic [31:0] SERIAL_BASE   = 32'hfff45000;
    localparam logic [31:0] LAN_BASE      = 32'hfff46000;
    localparam logic [31:0] SCSI_BASE     = 32'hfff47000;
    localparam logic [31:0] RSVACK_BASE   = 32'hfff70000;
    localparam logic [31:0] CODEMMU_BASE  = 32'hfff77000;
    localparam logic [31:0] DATAMMU_BASE  = 32'hfff7f000;
    localparam logic [31:0] RSVACK_END    = 32'hfff9ffff;
    localparam logic [31:0] BATTERY_BACKED_RAM_BASE    = 32'hfffc0000;
    localparam logic [31:0] VECT_BASE     = 32'hfffe0000;
    localparam logic [1:0]  VECT_BYTE     = 2'h3;
    // target select positions
    localparam int unsigned NT            = 16;
    typedef enum logic [4:0] {
        T_DRAM, T_VME, T_ROM, T_SRAM, T_LOCAL_CONTROL_STATUS_SPACE, T_GLOBAL_CONTROL_STATUS_SPACE, T_IOCTL, T_MEMCTL,
        T_SERIAL, T_LAN, T_SCSI, T_CODEMMU, T_DATAMMU, T_BATTERY_BACKED_RAM, T_A16, T_VECT,
        T_RSVACK, T_NONE
    } lbd_target_e;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_END  = 2'b11
    } lbd_state_e;
endpackage : lbd_pkg
`default_nettype wire

/* rtl/lbd_decoder.sv */
// lbd_decoder: local bus address decoder with bus timeout monitor
// assumes masters present a one-cycle cycleStart with stable address fields
//
// Function
// - only transfer types 0 and 1 decode as normal memory space
// - zero up to the dram extent goes to dram once enabled, D32
// - boot rom also answers at low 4MB until boot rom bit 20 clears
// - dram and local-to-vme decoders follow their enable inputs, which reset does not clear
// - 2MB reserved below sram is undecoded and times out
// - enabled timer ends an unfinished cycle with bus error ack
// - timeout selectable: 8us, 64us, 256us or infinite
// - timer does not count during vme bound cycles
// - 960KB io window goes to onboard io at 8, 16, 32 bit
// - narrow writes to local control status space end in bus error ack
// - global control space takes any write width, both take any read
// - vector bytes for levels 1 to 7 every four bytes, repeated
// - vector fetch with nothing pending gets no acknowledge
// - no-acknowledge reserved io areas rely on the timer
// - acknowledging reserved io areas near mmu windows complete cleanly
// - serial, lan and scsi chip selects decoded separately
// - 64KB battery backed ram and clock window, any width
// - top 64KB forwarded to vme a16 space, D16
`default_nettype none
module lbd_decoder
    import lbd_pkg::*;
#(
    parameter int unsigned TO_64_CYC  = TO_64US_CYC,
    parameter int unsigned TO_256_CYC = TO_256US_CYC
) (
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic          cycleStart,
    input  wire logic [31:0]   busAddr,
    input  wire logic [2:0]    transferTypeCode,
    input  wire logic          busWrite,
    input  wire logic [1:0]    busSize,
    input  wire logic          targetAck,
    input  wire logic          bootRomClear,
    input  wire logic          dramEnable,
    input  wire logic [31:0]   dramExtent,
    input  wire logic          vmeMapEnable,
    input  wire logic          vmeA16Enable,
    input  wire logic          timerEnable,
    input  wire logic [1:0]    timeoutSel,
    input  wire logic [7:1]    irqPending,
    output logic [NT:0]        targetSel,
    output logic [1:0]         portSize,
    output logic               busErrorAck,
    output logic               localAck,
    output logic               bootRomLowMap,
    output logic               cycleBusy
);
    function automatic lbd_target_e decodeTarget(
        input logic [31:0] a,
        input logic [2:0]  tt,
        input logic        wr,
        input logic [1:0]  sz,
        input logic        romLow,
        input logic        dramOn,
        input logic [31:0] extent,
        input logic        vmeOn,
        input logic        a16On,
        input logic [7:1]  pend
    );
        lbd_target_e t;
        t = T_NONE;
        if (tt > TT_NORMAL_MAX) begin
            t = T_NONE;
        end else if (a >= A16_BASE) begin
            t = a16On ? T_A16 : T_NONE;
        end else if (a >= IO_BASE) begin
            if (a >= VECT_BASE) begin
                if (a[1:0] == VECT_BYTE && !wr && sz == SZ_BYTE && a[4:2] != 3'h0
                    && pend[a[4:2]]) begin
                    t = T_VECT;
                end
            end else if (a >= BATTERY_BACKED_RAM_BASE && a < BATTERY_BACKED_RAM_BASE + 32'h00010000) begin
                t = T_BATTERY_BACKED_RAM;
            end else if (a >= RSVACK_BASE && a <= RSVACK_END) begin
                if (a[31:12] == CODEMMU_BASE[31:12]) begin
                    t = T_CODEMMU;
                end else if (a[31:12] == DATAMMU_BASE[31:12]) begin
                    t = T_DATAMMU;
                end else begin
                    t = T_RSVACK;
                end
            end else if (a[31:8] == LOCAL_CONTROL_STATUS_SPACE_BASE[31:8]) begin
                t = T_LOCAL_CONTROL_STATUS_SPACE;
            end else if (a[31:8] == GLOBAL_CONTROL_STATUS_SPACE_BASE[31:8]) begin
                t = T_GLOBAL_CONTROL_STATUS_SPACE;
            end else if (a[31:12] == IOCTL_BASE[31:12]) begin
                t = T_IOCTL;
            end else if (a[31:12] == MEMCTL_BASE[31:12]) begin
                t = T_MEMCTL;
            end else if (a[31:9] == SERIAL_BASE[31:9]) begin
                t = T_SERIAL;
            end else if (a[31:12] == LAN_BASE[31:12]) begin
                t = T_LAN;
            end else if (a[31:12] == SCSI_BASE[31:12]) begin
                t = T_SCSI;
            end else begin
                t = T_NONE;
            end
        end else if (a >= SRAM_BASE) begin
            t = T_SRAM;
        end else if (a >= RSV2M_BASE) begin
            t = T_NONE;
        end else if (a >= ROM_BASE) begin
            t = T_ROM;
        end else if (romLow && a <= ROM_LOW_END) begin
            t = T_ROM;
        end else if (dramOn && a < extent) begin
            t = T_DRAM;
        end else if (vmeOn && a <= VME_END) begin
            t = T_VME;
        end
        return t;
    endfunction : decodeTarget

    function automatic logic [1:0] targetPort(input lbd_target_e t);
        case (t)
            T_DRAM, T_ROM, T_SRAM, T_LOCAL_CONTROL_STATUS_SPACE, T_LAN, T_CODEMMU, T_DATAMMU: targetPort = PORT_D32;
            T_VME, T_A16:  targetPort = PORT_D16;
            T_SERIAL:      targetPort = PORT_D16;
            T_MEMCTL, T_VECT: targetPort = PORT_D8;
            default:       targetPort = PORT_ANY;
        endcase
    endfunction : targetPort

    lbd_state_e        state_q, state_d;
    logic [NT:0]       targetSel_q, targetSel_d;
    logic [1:0]        portSize_q, portSize_d;
    logic              busErrorAck_q, busErrorAck_d;
    logic              localAck_q, localAck_d;
    logic              romLow_q, romLow_d;
    logic              errPend_q, errPend_d;
    logic              rsvAck_q, rsvAck_d;
    logic [CNT_W-1:0]  count_q, count_d;
    logic [CNT_W-1:0]  limit;
    lbd_target_e       hit;
    logic              vmeBound;
    logic              timeoutHit;

    assign hit = decodeTarget(busAddr, transferTypeCode, busWrite, busSize, romLow_q,
                              dramEnable, dramExtent, vmeMapEnable, vmeA16Enable,
                              irqPending);
    assign vmeBound = targetSel_q[T_VME] | targetSel_q[T_A16];

    always_comb begin
        case (timeoutSel)
            TSEL_8US:   limit = CNT_W'(TO_8US_CYC);
            TSEL_64US:  limit = CNT_W'(TO_64_CYC);
            TSEL_256US: limit = CNT_W'(TO_256_CYC);
            default:    limit = '1;
        endcase
    end

    assign timeoutHit = timerEnable && timeoutSel != TSEL_INF && !vmeBound
                        && count_q == limit - CNT_W'(1);

    always_comb begin
        state_d       = state_q;
        targetSel_d   = targetSel_q;
        portSize_d    = portSize_q;
        busErrorAck_d = 1'b0;
        localAck_d    = 1'b0;
        romLow_d      = bootRomClear ? 1'b0 : romLow_q;
        errPend_d     = errPend_q;
        rsvAck_d      = rsvAck_q;
        count_d       = count_q;
        case (state_q)
            ST_IDLE: begin
                if (cycleStart) begin
                    state_d     = ST_RUN;
                    targetSel_d = '0;
                    if (hit != T_NONE) begin
                        targetSel_d[hit] = 1'b1;
                    end
                    portSize_d  = targetPort(hit);
                    errPend_d   = hit == T_LOCAL_CONTROL_STATUS_SPACE && busWrite && busSize != SZ_WORD;
                    rsvAck_d    = hit == T_RSVACK;
                    count_d     = '0;
                end
            end
            ST_RUN: begin
                if (errPend_q || timeoutHit) begin
                    busErrorAck_d = 1'b1;
                    state_d       = ST_END;
                end else if (rsvAck_q) begin
                    localAck_d = 1'b1;
                    state_d    = ST_END;
                end else if (targetAck) begin
                    state_d = ST_END;
                end else if (!vmeBound) begin
                    count_d = count_q + CNT_W'(1);
                end
                if (state_d == ST_END) begin
                    targetSel_d = '0;
                    errPend_d   = 1'b0;
                    rsvAck_d    = 1'b0;
                end
            end
            ST_END: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q       <= ST_IDLE;
            targetSel_q   <= '0;
            portSize_q    <= PORT_ANY;
            busErrorAck_q <= 1'b0;
            localAck_q    <= 1'b0;
            romLow_q      <= BOOT_ROM_RST;
            errPend_q     <= 1'b0;
            rsvAck_q      <= 1'b0;
            count_q       <= '0;
        end else begin
            state_q       <= state_d;
            targetSel_q   <= targetSel_d;
            portSize_q    <= portSize_d;
            busErrorAck_q <= busErrorAck_d;
            localAck_q    <= localAck_d;
            romLow_q      <= romLow_d;
            errPend_q     <= errPend_d;
            rsvAck_q      <= rsvAck_d;
            count_q       <= count_d;
        end
    end

    logic cycleBusy_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cycleBusy_q <= 1'b0;
        end else begin
            cycleBusy_q <= state_d == ST_RUN;
        end
    end

    assign targetSel     = targetSel_q;
    assign portSize      = portSize_q;
    assign busErrorAck   = busErrorAck_q;
    assign localAck      = localAck_q;
    assign bootRomLowMap = romLow_q;
    assign cycleBusy     = cycleBusy_q;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic startOk;
    assign startOk = cycleStart && state_q == ST_IDLE;

    sequence narrowLcsrWr;
        startOk && transferTypeCode <= TT_NORMAL_MAX && busAddr[31:8] == LOCAL_CONTROL_STATUS_SPACE_BASE[31:8]
        && busWrite && busSize != SZ_WORD;
    endsequence
    sequence errEnds;
        ##2 busErrorAck_q ##1 !busErrorAck_q;
    endsequence

    tt_separate_a: assert property (startOk && transferTypeCode > TT_NORMAL_MAX
        |=> targetSel_q == '0) else $error("special transfer type was decoded");
    rom_low_a: assert property (startOk && transferTypeCode <= TT_NORMAL_MAX
        && busAddr <= ROM_LOW_END && romLow_q |=> targetSel_q[T_ROM])
        else $error("low rom map missing");
    dram_off_a: assert property (startOk && !dramEnable |=> !targetSel_q[T_DRAM])
        else $error("dram selected while disabled");
    rsv_2mb_a: assert property (startOk && busAddr >= RSV2M_BASE && busAddr < SRAM_BASE
        |=> targetSel_q == '0) else $error("reserved 2MB decoded");
    local_control_status_space_narrow_a: assert property (narrowLcsrWr |-> errEnds)
        else $error("narrow local_control_status_space write not errored");
    one_target_a: assert property ($onehot0(targetSel_q))
        else $error("more than one target selected");
    vme_no_timeout_a: assert property (state_q == ST_RUN && vmeBound && !errPend_q
        |=> !busErrorAck_q && $stable(count_q)) else $error("timer ran on vme cycle");
    timeout_8us_a: assert property (state_q == ST_RUN && !errPend_q && !rsvAck_q
        && !targetAck && timerEnable && timeoutSel == TSEL_8US && !vmeBound
        && count_q == CNT_W'(TO_8US_CYC - 1) |=> busErrorAck_q && !cycleBusy_q)
        else $error("8us timeout missed");
    ack_stop_a: assert property (state_q == ST_RUN && targetAck && !errPend_q
        && !rsvAck_q && !timeoutHit |=> !busErrorAck_q && !cycleBusy_q)
        else $error("acknowledge did not end cycle");
    vect_nopend_a: assert property (startOk && busAddr >= VECT_BASE && busAddr <= IO_END
        && !irqPending[busAddr[4:2]] |=> !targetSel_q[T_VECT])
        else $error("vector acked with nothing pending");
    rsv_ack_a: assert property (startOk && transferTypeCode <= TT_NORMAL_MAX
        && busAddr >= RSVACK_BASE && busAddr < CODEMMU_BASE |=> ##1 localAck_q)
        else $error("acking reserved area did not ack");
endmodule : lbd_decoder
`default_nettype wire

/* sim/lbd_master_model.sv */
// lbd_master_model: local bus master that also plays the answering target
// assumes the decoder takes cycleStart only when idle and needs one end cycle
`default_nettype none
module lbd_master_model
    import lbd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        cycleBusy,
    input  wire logic        busErrorAck,
    input  wire logic        localAck,
    input  wire logic [NT:0] targetSel,
    input  wire logic [1:0]  portSize,
    output var logic         cycleStart,
    output var logic [31:0]  busAddr,
    output var logic [2:0]   transferTypeCode,
    output var logic         busWrite,
    output var logic [1:0]   busSize,
    output var logic         targetAck
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cycleStart = 1'b0;
        busAddr = 32'h5a5a5a5a;
        transferTypeCode = 3'h0;
        busWrite = 1'b0;
        busSize = 2'h0;
        targetAck = 1'b0;
    end

    // one cycle; outc 0 target ack, 1 bus error ack, 2 local ack, 3 no end
    task automatic run(input logic [31:0] a, input logic [2:0] tt, input logic wr,
                       input logic [1:0] sz, input int dly, input int lim,
                       output logic [NT:0] sel, output logic [1:0] ps,
                       output int outc, output int n);
        outc = 3;
        sel = '0;
        ps = 2'h0;
        @(posedge clk);
        cycleStart <= 1'b1;
        busAddr <= a;
        transferTypeCode <= tt;
        busWrite <= wr;
        busSize <= sz;
        @(posedge clk);
        cycleStart <= 1'b0;
        // select stands from the take edge until the end edge
        #1;
        sel = targetSel;
        ps = portSize;
        for (n = 0; n < lim; n++) begin
            @(posedge clk);
            targetAck <= (n == dly);
            #1;
            if (busErrorAck === 1'b1 || localAck === 1'b1 || cycleBusy !== 1'b1) begin
                outc = busErrorAck ? 1 : (localAck ? 2 : 0);
                // n counts edges from the take edge to the end edge
                n = n + 1;
                break;
            end
        end
        // released lines drift away from the last value
        busAddr <= ~busAddr;
        busWrite <= ~busWrite;
    endtask : run
endmodule : lbd_master_model
`default_nettype wire

/* sim/lbd_decoder_tb.sv */
// lbd_decoder_tb: self-checking bench for the local bus address decoder
// assumes the master model drives the bus side, config ports driven here
`default_nettype none
module lbd_decoder_tb;
    import lbd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T64 = 40;
    localparam int T256 = 80;
    localparam int TO8 = TO_8US_CYC;
    localparam logic [2:0] SKIP = 3'h4;
    logic        clk, rst_b, cycleStart, busWrite, targetAck, bootRomClear;
    logic        dramEnable, vmeMapEnable, vmeA16Enable, timerEnable;
    logic        busErrorAck, localAck, bootRomLowMap, cycleBusy;
    logic [31:0] busAddr, dramExtent;
    logic [2:0]  transferTypeCode, ttv;
    logic [1:0]  busSize, timeoutSel, portSize;
    logic [7:1]  irqPending;
    logic [NT:0] targetSel;
    int          n_mismatch = 0;
    int          compares = 0;

    lbd_decoder #(.TO_64_CYC(T64), .TO_256_CYC(T256)) lbd_decoder_i (.clk, .rst_b,
        .cycleStart, .busAddr, .transferTypeCode, .busWrite, .busSize, .targetAck,
        .bootRomClear, .dramEnable, .dramExtent, .vmeMapEnable, .vmeA16Enable,
        .timerEnable, .timeoutSel, .irqPending, .targetSel, .portSize, .busErrorAck,
        .localAck, .bootRomLowMap, .cycleBusy);
    lbd_master_model lbd_master_model_i (.clk, .cycleBusy, .busErrorAck, .localAck,
        .targetSel, .portSize, .cycleStart, .busAddr, .transferTypeCode, .busWrite,
        .busSize, .targetAck);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask : check

    task automatic cyc(input logic [31:0] a, input logic wr, input logic [1:0] sz,
                       input int dly, input lbd_target_e t, input logic [2:0] ep,
                       input int eo, input int en);
        logic [NT:0] sel;
        logic [1:0]  ps;
        int          o;
        int          n;
        lbd_master_model_i.run(a, ttv, wr, sz, dly, (eo == 3) ? en : en + 20, sel, ps, o, n);
        check(sel, (t == T_NONE) ? 32'h0 : (32'h1 << t), "target select");
        if (!ep[2]) check(ps, ep[1:0], "port size");
        check(o, eo, "ending kind");
        check(n, en, "ending cycle");
    endtask : cyc

    task automatic tmo(input logic [31:0] a, input int en);
        cyc(a, 1'b0, SZ_BYTE, -1, T_NONE, SKIP, (en > 1000) ? 3 : 1, en % 1000);
    endtask : tmo

    task automatic ack(input logic [31:0] a, input logic wr, input logic [1:0] sz,
                       input lbd_target_e t, input logic [2:0] ep);
        cyc(a, wr, sz, 1, t, ep, 0, 3);
    endtask : ack

    task automatic rst_chk();
        check({targetSel, portSize, busErrorAck, localAck, bootRomLowMap, cycleBusy},
              {17'h0, 2'h3, 4'b0010}, "reset state");
    endtask : rst_chk

    task automatic final_report();
        $display("compares %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        final_report();
    end

    initial begin
        rst_b = 1'b0;
        bootRomClear = 1'b0;
        dramEnable = 1'b0;
        dramExtent = 32'h01000000;
        vmeMapEnable = 1'b0;
        vmeA16Enable = 1'b0;
        timerEnable = 1'b1;
        timeoutSel = TSEL_8US;
        irqPending = 7'h00;
        ttv = 3'h0;
        repeat (5) @(posedge clk);
        rst_chk();
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            ttv = 3'(i);
            if (i < 2) ack(32'h0, 1'b0, SZ_WORD, T_ROM, 3'h0);
            else tmo(32'h0, TO8);
        end
        ttv = 3'h0;
        $display("test transfer types and boot map done");
        @(posedge clk);
        bootRomClear <= 1'b1;
        @(posedge clk);
        bootRomClear <= 1'b0;
        #1;
        check(bootRomLowMap, 32'h0, "boot map");
        tmo(32'h100, TO8);
        @(posedge clk);
        dramEnable <= 1'b1;
        ack(32'h00fffffc, 1'b1, SZ_WORD, T_DRAM, 3'h0);
        tmo(32'h01000000, TO8);
        @(posedge clk);
        vmeMapEnable <= 1'b1;
        cyc(32'h01000000, 1'b0, SZ_WORD, 850, T_VME, SKIP, 0, 852);
        $display("test dram and vme done");
        tmo(RSV2M_BASE + 32'h1ffffc, TO8);
        cyc(LOCAL_CONTROL_STATUS_SPACE_BASE, 1'b1, SZ_HALF, -1, T_LOCAL_CONTROL_STATUS_SPACE, 3'h0, 1, 1);
        cyc(LOCAL_CONTROL_STATUS_SPACE_BASE + 32'h4, 1'b1, SZ_BYTE, -1, T_LOCAL_CONTROL_STATUS_SPACE, 3'h0, 1, 1);
        ack(LOCAL_CONTROL_STATUS_SPACE_BASE + 32'hfc, 1'b1, SZ_WORD, T_LOCAL_CONTROL_STATUS_SPACE, 3'h0);
        ack(LOCAL_CONTROL_STATUS_SPACE_BASE, 1'b0, SZ_BYTE, T_LOCAL_CONTROL_STATUS_SPACE, 3'h0);
        ack(GLOBAL_CONTROL_STATUS_SPACE_BASE, 1'b1, SZ_BYTE, T_GLOBAL_CONTROL_STATUS_SPACE, SKIP);
        tmo(IO_BASE, TO8);
        ack(IOCTL_BASE, 1'b0, SZ_HALF, T_IOCTL, SKIP);
        ack(SERIAL_BASE + 32'h1fe, 1'b1, SZ_HALF, T_SERIAL, SKIP);
        tmo(SERIAL_BASE + 32'h200, TO8);
        ack(LAN_BASE, 1'b1, SZ_HALF, T_LAN, 3'h0);
        ack(LAN_BASE + 32'h2, 1'b1, SZ_HALF, T_LAN, 3'h0);
        ack(SCSI_BASE, 1'b0, SZ_BYTE, T_SCSI, SKIP);
        cyc(RSVACK_BASE, 1'b0, SZ_WORD, -1, T_RSVACK, SKIP, 2, 1);
        cyc(RSVACK_END - 32'h3, 1'b1, SZ_WORD, -1, T_RSVACK, SKIP, 2, 1);
        ack(CODEMMU_BASE, 1'b0, SZ_WORD, T_CODEMMU, 3'h0);
        ack(DATAMMU_BASE, 1'b1, SZ_WORD, T_DATAMMU, 3'h0);
        ack(BATTERY_BACKED_RAM_BASE + 32'h1f2c, 1'b0, SZ_WORD, T_BATTERY_BACKED_RAM, 3'h3);
        tmo(32'hfffdfffc, TO8);
        $display("test local io map done");
        @(posedge clk);
        irqPending <= 7'h04;
        tmo(VECT_BASE + 32'h7, TO8);
        ack(VECT_BASE + 32'h2f, 1'b0, SZ_BYTE, T_VECT, 3'h2);
        @(posedge clk);
        irqPending <= 7'h7f;
        for (int i = 1; i < 8; i++) begin
            ack(VECT_BASE + 32'h24 * i + 32'h3, 1'b0, SZ_BYTE, T_VECT, 3'h2);
        end
        tmo(VECT_BASE + 32'h23, TO8);
        @(posedge clk);
        vmeA16Enable <= 1'b1;
        dramExtent <= 32'hffffffff;
        ack(A16_BASE + 32'h10, 1'b1, SZ_HALF, T_A16, SKIP);
        ack(ROM_BASE, 1'b0, SZ_WORD, T_ROM, 3'h0);
        ack(LOCAL_CONTROL_STATUS_SPACE_BASE, 1'b0, SZ_WORD, T_LOCAL_CONTROL_STATUS_SPACE, 3'h0);
        $display("test vectors and overlap done");
        @(posedge clk);
        timeoutSel <= TSEL_64US;
        tmo(RSV2M_BASE, T64);
        @(posedge clk);
        timeoutSel <= TSEL_256US;
        tmo(RSV2M_BASE, T256);
        @(posedge clk);
        timeoutSel <= TSEL_INF;
        tmo(RSV2M_BASE, 1300);
        @(posedge clk);
        rst_b <= 1'b0;
        timeoutSel <= TSEL_8US;
        timerEnable <= 1'b0;
        repeat (5) @(posedge clk);
        rst_chk();
        rst_b <= 1'b1;
        tmo(RSV2M_BASE, 1900);
        $display("test timeout settings done");
        final_report();
    end
endmodule : lbd_decoder_tb
`default_nettype wire
